// File: power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller #(
    parameter int WAKE_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Special-function register bus from the CPU
    input  wire logic                  sfr_write,
    input  wire logic                  sfr_read,
    input  wire logic [7:0]            sfr_addr,
    input  wire logic [7:0]            sfr_page,
    input  wire logic [7:0]            sfr_wdata,
    output logic      [7:0]            sfr_rdata,
    // CPU handshake
    input  wire logic                  instr_done,
    input  wire logic                  clock_is_24m5,
    output logic                       cpu_halt,
    output logic                       cpu_restart,
    output logic      [15:0]           restart_address,
    // Wake and reset sources
    input  wire logic                  irq_pending,
    input  wire logic [WAKE_WIDTH-1:0] wake_event,
    input  wire logic                  watchdog_reset,
    input  wire logic                  missing_clock_reset,
    input  wire logic                  missing_clock_enable,
    input  wire logic                  other_reset,
    input  wire logic                  reset_pin_n,
    // Clock and regulator controls
    output logic                       periph_clock_en,
    output logic                       osc_24m5_en,
    output logic                       osc_49m_en,
    output logic                       regulator_standby,
    output logic                       regulator_off,
    output logic                       pin_hold,
    output logic                       por_cause,
    output logic      [6:0]            power_mode
);
    import power_mode_pkg::*;

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    power_mode_t                mode_reg;
    power_mode_t                mode_next;
    logic [7:0]                 power_control_reg;
    logic [7:0]                 regulator_control_reg;
    logic [WAKE_WIDTH-1:0]      power_status_reg;
    logic [7:0]                 pending_reg;
    logic [7:0]                 recover_count_reg;
    logic                       restart_reg;
    logic                       por_cause_reg;
    logic                       exit_pin_reg;
    logic                       any_reset;
    logic                       shutdown_exit;
    logic                       wake_any;
    logic                       ctrl_write;

    sfr_access_if acc ();
    assign acc.write_strobe = sfr_write;
    assign acc.write_addr   = sfr_addr;
    assign acc.write_data   = sfr_wdata;
    assign acc.page         = sfr_page;

    sfr_decoder u_decoder (
        .acc (acc)
    );

    // Wake flags capture while suspended or snoozing
    wake_status #(
        .WAKE_WIDTH (WAKE_WIDTH)
    ) u_wake (
        .clock       (clock),
        .rstn        (rstn),
        .wake_event  (wake_event),
        .capture     (mode_reg == MODE_SUSPEND || mode_reg == MODE_SNOOZE),
        .clear_write (sfr_write && acc.hit_status),
        .clear_data  (sfr_wdata[WAKE_WIDTH-1:0]),
        .flags_reg   (power_status_reg)
    );

    assign ctrl_write = sfr_write && acc.hit_control;
    assign wake_any   = |wake_event;
    // missing clock reset only when enabled
    assign any_reset  = watchdog_reset || other_reset || !reset_pin_n
                        || (missing_clock_reset && missing_clock_enable);
    assign shutdown_exit = !reset_pin_n;

    // ------------------------------------------------------------
    // Request latch: takes effect when the writing instruction ends
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pending_reg <= POWER_CONTROL_RESET;
        end else if (ctrl_write) begin
            pending_reg <= sfr_wdata;
        end else if (instr_done) begin
            pending_reg <= POWER_CONTROL_RESET;
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_NORMAL: begin
                if (instr_done && !ctrl_write) begin
                    if (pending_reg[STOP_BIT] && regulator_control_reg[SHUTDOWN_SEL]) begin
                        mode_next = MODE_SHUTDOWN;
                    end else if (pending_reg[STOP_BIT]) begin
                        mode_next = MODE_STOP;
                    // snooze only from the 24.5 MHz oscillator
                    end else if (pending_reg[SNOOZE_BIT] && clock_is_24m5) begin
                        mode_next = MODE_SNOOZE;
                    // suspend only from the 24.5 MHz oscillator
                    end else if (pending_reg[SUSPEND_BIT] && clock_is_24m5) begin
                        mode_next = MODE_SUSPEND;
                    end else if (pending_reg[IDLE_BIT]) begin
                        mode_next = MODE_IDLE;
                    end
                end
            end
            MODE_IDLE:     mode_next = irq_pending ? MODE_NORMAL : MODE_IDLE;
            MODE_SUSPEND:  mode_next = wake_any ? MODE_NORMAL : MODE_SUSPEND;
            MODE_SNOOZE:   mode_next = wake_any ? MODE_RECOVER : MODE_SNOOZE;
            MODE_RECOVER:  mode_next = (recover_count_reg == 8'h00) ? MODE_NORMAL
                                                                    : MODE_RECOVER;
            // stop ignores wakes; only reset below
            MODE_STOP:     mode_next = MODE_STOP;
            MODE_SHUTDOWN: mode_next = MODE_SHUTDOWN;
            default:       mode_next = MODE_NORMAL;
        endcase
    end

    // Mode register with reset exits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= MODE_NORMAL;
        end else if (mode_reg == MODE_SHUTDOWN) begin
            if (shutdown_exit) begin
                mode_reg <= MODE_NORMAL;
            end
        end else if (any_reset) begin
            mode_reg <= MODE_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // Regulator recovery counter
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            recover_count_reg <= 8'h00;
        end else if (mode_reg == MODE_SNOOZE) begin
            recover_count_reg <= 8'(REG_RECOVER_CYCLES - 1);
        end else if (recover_count_reg != 8'h00) begin
            recover_count_reg <= recover_count_reg - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Control register: hardware clears halt bit on wake
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_control_reg <= POWER_CONTROL_RESET;
        end else if (any_reset && mode_reg != MODE_SHUTDOWN) begin
            power_control_reg <= POWER_CONTROL_RESET;
        end else if (ctrl_write) begin
            power_control_reg <= sfr_wdata;
        end else if (mode_reg != MODE_NORMAL && mode_next == MODE_NORMAL) begin
            power_control_reg <= POWER_CONTROL_RESET;
        end else if (mode_reg == MODE_NORMAL && instr_done && mode_next == MODE_NORMAL) begin
            power_control_reg <= POWER_CONTROL_RESET;
        end
    end

    // Regulator control register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regulator_control_reg <= REGULATOR_CONTROL_RESET;
        end else if (mode_reg == MODE_SHUTDOWN && shutdown_exit) begin
            regulator_control_reg <= REGULATOR_CONTROL_RESET;
        end else if (sfr_write && acc.hit_regulator) begin
            regulator_control_reg <= sfr_wdata;
        end
    end

    // ------------------------------------------------------------
    // Restart request and reset cause
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            restart_reg   <= 1'b0;
            por_cause_reg <= 1'b1;
        end else if (mode_reg == MODE_SHUTDOWN) begin
            restart_reg   <= shutdown_exit;
            por_cause_reg <= por_cause_reg | shutdown_exit;
        end else begin
            restart_reg   <= any_reset;
            por_cause_reg <= (any_reset && !exit_pin_reg) ? 1'b0 : por_cause_reg;
        end
    end

    // Pin still held low after leaving shutdown: keeps the power-on cause,
    // otherwise a long pin press would be reported as an ordinary reset
    // held pin keeps cause
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            exit_pin_reg <= 1'b0;
        end else begin
            exit_pin_reg <= (mode_reg == MODE_SHUTDOWN || exit_pin_reg) && shutdown_exit;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // idle keeps clocks and peripherals on
    // CPU restarts from the fixed reset vector
    assign cpu_halt          = mode_reg != MODE_NORMAL;
    assign periph_clock_en   = mode_reg == MODE_NORMAL || mode_reg == MODE_IDLE;
    assign osc_24m5_en       = periph_clock_en || mode_reg == MODE_RECOVER;
    assign osc_49m_en        = periph_clock_en;
    assign regulator_standby = mode_reg == MODE_SNOOZE;
    assign regulator_off     = mode_reg == MODE_SHUTDOWN;
    assign pin_hold          = mode_reg == MODE_SHUTDOWN;
    assign cpu_restart       = restart_reg;
    assign restart_address   = RESET_VECTOR;
    assign por_cause         = por_cause_reg;
    assign power_mode        = mode_reg;

    // Read data
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_read && acc.hit_control) begin
            sfr_rdata = power_control_reg;
        end else if (sfr_read && acc.hit_regulator) begin
            sfr_rdata = regulator_control_reg;
        end else if (sfr_read && acc.hit_status) begin
            sfr_rdata = 8'(power_status_reg);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_idle_entry: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_NORMAL && instr_done && !ctrl_write && pending_reg == 8'h01
        && !any_reset |=> mode_reg == MODE_IDLE)
        else $error("idle not entered");
    a_idle_wake: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_IDLE && irq_pending && !any_reset
        |=> mode_reg == MODE_NORMAL && power_control_reg[IDLE_BIT] == 1'b0)
        else $error("idle wake failed");
    a_idle_clocks: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_IDLE |-> periph_clock_en && osc_24m5_en)
        else $error("clocks off in idle");
    a_reset_restart: assert property (@(posedge clock) disable iff (!rstn)
        any_reset && mode_reg != MODE_SHUTDOWN |=> cpu_restart && mode_reg == MODE_NORMAL)
        else $error("reset did not restart");
    a_stop_holds: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_STOP && !any_reset |=> mode_reg == MODE_STOP)
        else $error("stop left without reset");
    a_snooze_recover: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_SNOOZE && wake_any && !any_reset |=> mode_reg == MODE_RECOVER)
        else $error("snooze skipped recovery");
    a_shutdown_exit: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_SHUTDOWN && shutdown_exit |=> por_cause && cpu_restart)
        else $error("shutdown exit not power-on");
    a_suspend_ignored: assert property (@(posedge clock) disable iff (!rstn)
        mode_reg == MODE_NORMAL && instr_done && !ctrl_write && !clock_is_24m5
        && !pending_reg[STOP_BIT] && !pending_reg[IDLE_BIT] |=> mode_reg == MODE_NORMAL)
        else $error("suspend off wrong clock");
endmodule : power_mode_controller
`default_nettype wire

// File: power_mode_pkg.sv
package power_mode_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h87;
    localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hc9;
    localparam logic [7:0] POWER_STATUS_ADDR      = 8'h85;
    localparam logic [7:0] REGULATOR_CONTROL_PAGE = 8'h00;
    localparam logic [7:0] REGULATOR_CONTROL_PAGE2 = 8'h20;
    localparam logic [7:0] POWER_STATUS_PAGE      = 8'h00;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int IDLE_BIT     = 0;
    localparam int STOP_BIT     = 1;
    localparam int SUSPEND_BIT  = 2;
    localparam int SNOOZE_BIT   = 3;
    localparam int SHUTDOWN_SEL = 7;
    localparam logic [7:0] POWER_CONTROL_RESET     = 8'h00;
    localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] POWER_STATUS_RESET      = 8'h00;
    localparam logic [15:0] RESET_VECTOR           = 16'h0000;

    // ------------------------------------------------------------
    // Timing: regulator recovery time before resuming from snooze
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_PS     = 5000;
    localparam int REG_RECOVER_NS      = 20;
    localparam int REG_RECOVER_CYCLES  = (REG_RECOVER_NS * 1000 + CLOCK_PERIOD_PS - 1)
                                         / CLOCK_PERIOD_PS;

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        MODE_NORMAL   = 7'h01,
        MODE_IDLE     = 7'h02,
        MODE_SUSPEND  = 7'h04,
        MODE_SNOOZE   = 7'h08,
        MODE_STOP     = 7'h10,
        MODE_SHUTDOWN = 7'h20,
        MODE_RECOVER  = 7'h40
    } power_mode_t;

endpackage : power_mode_pkg

// File: sfr_access_if.sv
`timescale 1ns/1ps
`default_nettype none
// Register-file access from the CPU special-function bus
interface sfr_access_if;
    logic       write_strobe;
    logic [7:0] write_addr;
    logic [7:0] write_data;
    logic [7:0] page;
    logic       hit_control;
    logic       hit_regulator;
    logic       hit_status;

    modport decoder (
        input  write_strobe, write_addr, write_data, page,
        output hit_control, hit_regulator, hit_status
    );
    modport core (
        output write_strobe, write_addr, write_data, page,
        input  hit_control, hit_regulator, hit_status
    );
endinterface : sfr_access_if
`default_nettype wire

// File: sfr_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_decoder (
    // Access port
    sfr_access_if.decoder acc
);
    import power_mode_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic regulator_page(input logic [7:0] pg);
        return (pg == REGULATOR_CONTROL_PAGE) || (pg == REGULATOR_CONTROL_PAGE2);
    endfunction : regulator_page

    // Control register answers on every page
    // page-independent decode for control only; regulator and status also match the page
    assign acc.hit_control   = acc.write_addr == POWER_CONTROL_ADDR;
    assign acc.hit_regulator = (acc.write_addr == REGULATOR_CONTROL_ADDR)
                               && regulator_page(acc.page);
    assign acc.hit_status    = (acc.write_addr == POWER_STATUS_ADDR)
                               && (acc.page == POWER_STATUS_PAGE);
endmodule : sfr_decoder
`default_nettype wire

// File: wake_status.sv
`timescale 1ns/1ps
`default_nettype none
module wake_status #(
    parameter int WAKE_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Events and software clear
    input  wire logic [WAKE_WIDTH-1:0] wake_event,
    input  wire logic                  capture,
    input  wire logic                  clear_write,
    input  wire logic [WAKE_WIDTH-1:0] clear_data,
    // Flags
    output logic      [WAKE_WIDTH-1:0] flags_reg
);
    import power_mode_pkg::*;

    // ------------------------------------------------------------
    // Sticky wake flags
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WAKE_WIDTH; i++) begin : g_flag
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    flags_reg[i] <= POWER_STATUS_RESET[i];
                end else if (capture && wake_event[i]) begin
                    flags_reg[i] <= 1'b1;
                end else if (clear_write && !clear_data[i]) begin
                    flags_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : wake_status
`default_nettype wire

// File: cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    // Clock and read data
    input  wire logic       clock,
    input  wire logic [7:0] sfr_rdata,
    // Bus and completion
    output logic            sfr_write,
    output logic            sfr_read,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_page,
    output logic      [7:0] sfr_wdata,
    output logic            instr_done
);
    // Bus idle at start
    initial begin
        {sfr_write, sfr_read, instr_done} = 3'h0;
        {sfr_addr, sfr_page, sfr_wdata} = 24'h0;
    end
    // done pulse stands for two-byte follow-up
    task automatic wr(input logic [7:0] a, p, d);
        @(posedge clock);
        sfr_write <= 1'b1;
        sfr_addr  <= a;
        sfr_page  <= p;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_write  <= 1'b0;
        sfr_wdata  <= ~d;
        instr_done <= 1'b1;
        @(posedge clock);
        instr_done <= 1'b0;
    endtask : wr
    // Read data is combinational, taken at the closing edge
    task automatic rd(input logic [7:0] a, p, output logic [7:0] d);
        @(posedge clock);
        sfr_read <= 1'b1;
        sfr_addr <= a;
        sfr_page <= p;
        @(posedge clock);
        d = sfr_rdata;
        sfr_read <= 1'b0;
        sfr_addr <= ~a;
    endtask : rd
endmodule : cpu_model
`default_nettype wire

// File: power_mode_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb;
    import power_mode_pkg::*;
    typedef struct {logic [7:0] req; logic fast; logic [6:0] mode;} row_t;
    logic clock = 1'b0, rstn = 1'b0, clock_is_24m5 = 1'b1, irq_pending = 1'b0;
    logic watchdog_reset = 1'b0, missing_clock_reset = 1'b0, missing_clock_enable = 1'b0;
    logic other_reset = 1'b0, reset_pin_n = 1'b1;
    logic [7:0] wake_event = 8'h00;
    logic sfr_write, sfr_read, instr_done, cpu_halt, cpu_restart, periph_clock_en;
    logic osc_24m5_en, osc_49m_en, regulator_standby, regulator_off, pin_hold, por_cause;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, rdat;
    logic [15:0] restart_address;
    logic [6:0] power_mode;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    // Entry rows: request, fast clock, mode expected
    row_t rows [7] = '{'{8'h01, 1'b1, MODE_IDLE}, '{8'h04, 1'b1, MODE_SUSPEND},
        '{8'h08, 1'b1, MODE_SNOOZE}, '{8'h02, 1'b1, MODE_STOP}, '{8'h04, 1'b0, MODE_NORMAL},
        '{8'h08, 1'b0, MODE_NORMAL}, '{8'h0a, 1'b1, MODE_STOP}};

    // Clock
    always #2.5 clock = ~clock;

    power_mode_controller power_mode_controller_i (
        .clock(clock), .rstn(rstn), .sfr_write(sfr_write), .sfr_read(sfr_read),
        .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .instr_done(instr_done), .clock_is_24m5(clock_is_24m5),
        .cpu_halt(cpu_halt), .cpu_restart(cpu_restart), .restart_address(restart_address),
        .irq_pending(irq_pending), .wake_event(wake_event), .watchdog_reset(watchdog_reset),
        .missing_clock_reset(missing_clock_reset), .other_reset(other_reset),
        .missing_clock_enable(missing_clock_enable), .reset_pin_n(reset_pin_n),
        .periph_clock_en(periph_clock_en), .osc_24m5_en(osc_24m5_en),
        .osc_49m_en(osc_49m_en), .regulator_standby(regulator_standby),
        .regulator_off(regulator_off), .pin_hold(pin_hold), .por_cause(por_cause),
        .power_mode(power_mode));
    cpu_model cpu_model_i (
        .clock(clock), .sfr_rdata(sfr_rdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
        .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wdata(sfr_wdata),
        .instr_done(instr_done));

    // Compare and count
    task automatic check(input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    // Bounded wait for a mode or a restart pulse
    task automatic wait_until(input logic [6:0] m, input logic rs);
        int k;
        #1;
        for (k = 0; k < 40; k++) begin
            if (rs ? cpu_restart === 1'b1 : power_mode === m) break;
            @(posedge clock);
            #1;
        end
        if (k == 40) begin
            bad_count++;
            $display("unexpected at %0t: wait ran out", $time);
            summarize();
        end
    endtask : wait_until

    // Run-time limit
    initial begin
        #200000;
        bad_count++;
        $display("unexpected at %0t: run limit", $time);
        summarize();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        #1;
        check(por_cause, 1'b1);
        cpu_model_i.rd(POWER_CONTROL_ADDR, 8'h00, rdat);
        check(rdat, POWER_CONTROL_RESET);
        cpu_model_i.rd(8'h90, 8'h00, rdat);
        check(rdat, 8'h00);
        // fast clock chosen per row before the request
        foreach (rows[i]) begin
            clock_is_24m5 <= rows[i].fast;
            cpu_model_i.wr(POWER_CONTROL_ADDR, 8'h00, rows[i].req);
            #1;
            check(power_mode, rows[i].mode);
            check(cpu_halt, rows[i].mode != MODE_NORMAL);
            @(posedge clock);
            watchdog_reset <= 1'b1;
            @(posedge clock);
            watchdog_reset <= 1'b0;
            wait_until(MODE_NORMAL, 1'b1);
            check(restart_address, RESET_VECTOR);
            wait_until(MODE_NORMAL, 1'b0);
        end
        // Idle from another page, woken by interrupt
        cpu_model_i.wr(POWER_CONTROL_ADDR, 8'h10, 8'h01);
        #1;
        check({periph_clock_en, power_mode}, {1'b1, MODE_IDLE});
        irq_pending <= 1'b1;
        wait_until(MODE_NORMAL, 1'b0);
        check(cpu_restart, 1'b0);
        irq_pending <= 1'b0;
        cpu_model_i.rd(POWER_CONTROL_ADDR, 8'h20, rdat);
        check(rdat[IDLE_BIT], 1'b0);
        // Snooze, wake, regulator recovery, wake flags
        cpu_model_i.wr(POWER_CONTROL_ADDR, 8'h00, 8'h08);
        #1;
        check({regulator_standby, osc_24m5_en, osc_49m_en}, 3'b100);
        wake_event <= 8'h04;
        wait_until(MODE_RECOVER, 1'b0);
        for (n = 0; n < 20 && power_mode === MODE_RECOVER; n++) begin
            @(posedge clock);
            #1;
        end
        check(n, REG_RECOVER_CYCLES);
        check(power_mode, MODE_NORMAL);
        wake_event <= 8'h00;
        cpu_model_i.rd(POWER_STATUS_ADDR, POWER_STATUS_PAGE, rdat);
        check(rdat, 8'h04);
        cpu_model_i.wr(POWER_STATUS_ADDR, POWER_STATUS_PAGE, 8'hfb);
        cpu_model_i.rd(POWER_STATUS_ADDR, POWER_STATUS_PAGE, rdat);
        check(rdat, 8'h00);
        // Stop ignores wakes, missing clock reset ends it
        cpu_model_i.wr(POWER_CONTROL_ADDR, 8'h00, 8'h02);
        irq_pending <= 1'b1;
        wake_event <= 8'hff;
        repeat (8) @(posedge clock);
        #1;
        check({periph_clock_en, power_mode}, {1'b0, MODE_STOP});
        missing_clock_reset <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(power_mode, MODE_STOP);
        missing_clock_enable <= 1'b1;
        wait_until(MODE_NORMAL, 1'b1);
        {irq_pending, missing_clock_reset} <= 2'b00;
        wake_event <= 8'h00;
        check(por_cause, 1'b0);
        // Shutdown, left only by the reset pin
        cpu_model_i.wr(REGULATOR_CONTROL_ADDR, REGULATOR_CONTROL_PAGE2, 8'h80);
        cpu_model_i.wr(POWER_CONTROL_ADDR, 8'h00, 8'h02);
        #1;
        check({regulator_off, pin_hold, power_mode}, {2'b11, MODE_SHUTDOWN});
        other_reset <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(power_mode, MODE_SHUTDOWN);
        other_reset <= 1'b0;
        reset_pin_n <= 1'b0;
        wait_until(MODE_NORMAL, 1'b1);
        repeat (3) @(posedge clock);
        reset_pin_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check({por_cause, power_mode}, {1'b1, MODE_NORMAL});
        // Mid-run reset returns to the power-on state
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        check({por_cause, cpu_restart, cpu_halt, power_mode}, {3'b100, MODE_NORMAL});
        summarize();
    end
endmodule : power_mode_controller_tb
`default_nettype wire
